/* design/msl_defs.svh */
`ifndef MSL_DEFS_SVH
`define MSL_DEFS_SVH

`define MSL_CLK_HZ          40000000
`define MSL_BAUD_UNIT       4800
`define MSL_BIT_CYC(n)      (`MSL_CLK_HZ / (`MSL_BAUD_UNIT * (n)))
`define MSL_OP_READ         8'h4a
`define MSL_OP_WRITE        8'h49
`define MSL_OP_INDEXED_READ_CMD        8'h1a
`define MSL_OP_INDEXED_WRITE_CMD       8'h19
`define MSL_OP_STACK_POINTER_READ_CMD       8'h0c
`define MSL_OP_RUN          8'h28
`define MSL_ERASED          8'hff
`define MSL_SEC_BASE        16'hfff6
`define MSL_SEC_COUNT       8
`define MSL_SEC_FLAG_ADDR   16'h0060
`define MSL_SEC_FLAG_BIT    6
`define MSL_BREAK_LOW_BITS  10
`define MSL_BREAK_GAP_BITS  2
`define MSL_INVALID_DATA    8'had

`endif

/* design/msl_pkg.sv */
package msl_pkg;
  typedef enum logic [3:0] {
    MSL_SECURE, MSL_SEC_MEMRD, MSL_READY_BRK, MSL_IDLE, MSL_ADDR_HI, MSL_ADDR_LO,
    MSL_DATA_IN, MSL_MEM_RD, MSL_MEM_WR, MSL_SEND, MSL_SEND_SP, MSL_BRK_GAP, MSL_BRK_ECHO
  } msl_state_t;
endpackage : msl_pkg

/* design/msl_uart.sv */
`timescale 1ns/1ps
`include "msl_defs.svh"
// Half-duplex bit engine on one pin: receive, transmit byte, transmit break.
module msl_uart
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe,
  input  wire logic        tx_go,
  input  wire logic        tx_brk,
  input  wire logic [7:0]  tx_data,
  output logic             tx_busy,
  output logic             rx_valid,
  output logic             rx_break,
  output logic [7:0]       rx_data
);
  logic [15:0] rcnt_reg;
  logic [3:0]  rbit_reg;
  logic        ract_reg;
  logic [8:0]  rsh_reg;
  logic [15:0] tcnt_reg;
  logic [3:0]  tbit_reg;
  logic [9:0]  tsh_reg;
  logic        tact_reg;
  logic        lprev_reg;

  wire r_tick = (rcnt_reg == 16'h0000);
  wire t_tick = (tcnt_reg == 16'h0000);
  wire r_last = ract_reg && r_tick && (rbit_reg == 4'h9);

  // A start needs a falling edge, so the tail of a received break cannot open a false frame
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lprev_reg <= 1'b1;
    else
      lprev_reg <= line_in;
  end

  // Receiver samples mid-bit; frame of start, 8 data LSB first, stop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ract_reg <= 1'b0;
      rcnt_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg  <= 9'h000;
    end
    else if (!ract_reg)
    begin
      if (!line_in && lprev_reg && !tact_reg)
      begin
        ract_reg <= 1'b1;
        rcnt_reg <= bit_cyc >> 1;
        rbit_reg <= 4'h0;
      end
    end
    else if (r_tick)
    begin
      rcnt_reg <= bit_cyc - 16'h0001;
      rbit_reg <= rbit_reg + 4'h1;
      if (rbit_reg != 4'h0)
        rsh_reg <= {line_in, rsh_reg[8:1]};
      if (rbit_reg == 4'h9)
        ract_reg <= 1'b0;
    end
    else
      rcnt_reg <= rcnt_reg - 16'h0001;
  end

  wire [8:0] frame = {line_in, rsh_reg[8:1]};
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_valid <= 1'b0;
      rx_break <= 1'b0;
      rx_data  <= 8'h00;
    end
    else
    begin
      rx_valid <= r_last && frame[8];
      rx_break <= r_last && (frame == 9'h000);
      if (r_last)
        rx_data <= frame[7:0];
    end
  end

  // Transmitter: a break is ten low bit times, data is a framed byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tact_reg <= 1'b0;
      tcnt_reg <= 16'h0000;
      tbit_reg <= 4'h0;
      tsh_reg  <= 10'h3ff;
    end
    else if (!tact_reg)
    begin
      if (tx_go)
      begin
        tact_reg <= 1'b1;
        tcnt_reg <= bit_cyc - 16'h0001;
        tbit_reg <= 4'h0;
        tsh_reg  <= tx_brk ? 10'h000 : {1'b1, tx_data, 1'b0};
      end
    end
    else if (t_tick)
    begin
      tcnt_reg <= bit_cyc - 16'h0001;
      tsh_reg  <= {1'b1, tsh_reg[9:1]};
      tbit_reg <= tbit_reg + 4'h1;
      if (tbit_reg == 4'h9)
        tact_reg <= 1'b0;
    end
    else
      tcnt_reg <= tcnt_reg - 16'h0001;
  end

  // Pin is driven only while sending; idle line is pulled high outside
  assign line_out = tact_reg ? tsh_reg[0] : 1'b1;
  assign line_oe  = tact_reg;
  assign tx_busy  = tact_reg;
endmodule : msl_uart

/* design/msl_monitor.sv */
`timescale 1ns/1ps
`include "msl_defs.svh"
// Function
// - Erased reset vectors force monitor entry via reset
// - Watchdog held off in forced monitor mode
// - Non-power-on resets return to forced monitor
// - NRZ mark/space bytes on the monitor pin
// - Rate 4800 to 28800, same both ways
// - Echo every received byte immediately
// - Command results follow echo of last byte
// - Break is start plus nine low bits
// - Hold pin high two bits before break echo
// - Six commands supported
// - Read 4A with address high first
// - Indexed write 19 stores at last plus one
// - Indexed access steps through 64K space
// - Baud select pin picks 4800 or 9600
// - Baud scales with multiplier N one to six
// - Compare eight bytes with FFF6 through FFFD
// - Match unlocks flash until next power-on
// - Mismatch: invalid reads, execution forces reset
// - Ready break only after eight security bytes
// - Set bit 6 at RAM 60 on success; this design never writes RAM 60
// - Bulk erase makes security bytes read FF; this design only sets security_erased on bulk_erase_done
module msl_monitor
  import msl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_pulse,
  input  wire logic        sys_reset_pulse,
  input  wire logic        vector_fetch,
  input  wire logic [7:0]  vector_data,
  input  wire logic        high_voltage_entry_pin,
  input  wire logic        baud_select_pin,
  input  wire logic [2:0]  vco_mult_n,
  input  wire logic        monitor_serial_pin_in,
  output logic             monitor_serial_pin_out,
  output logic             monitor_serial_pin_oe,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_is_flash,
  input  wire logic [15:0] stack_pointer,
  input  wire logic        bulk_erase_done,
  output logic             monitor_mode,
  output logic             forced_monitor,
  output logic             internal_reset_req,
  output logic             illegal_addr_reset,
  output logic             watchdog_enable,
  output logic             flash_unlocked,
  output logic             run_user,
  output logic             security_erased
);
  msl_state_t  state_reg;
  logic [15:0] addr_reg;
  logic [7:0]  op_reg;
  logic [7:0]  data_reg;
  logic [3:0]  sec_idx_reg;
  logic        sec_ok_reg;
  logic        sec_done_reg;
  logic        forced_reg;
  logic        baud_sel_reg;
  logic [2:0]  mult_reg;
  logic        ireset_reg;
  logic        erased_reg;
  logic        iw_pending_reg;
  logic        sp_lo_reg;
  logic [15:0] gap_cnt_reg;
  logic        strap_pending_reg;
  logic        tx_go;
  logic        tx_brk;
  logic [7:0]  tx_data;
  logic        tx_busy;
  logic        rx_valid;
  logic        rx_break;
  logic [7:0]  rx_data;

  // Rate is 4800 per multiplier step; strap low doubles it, capped at the top legal rate
  wire [2:0]  n_eff   = (mult_reg == 3'd0) ? 3'd1 : ((mult_reg > 3'd6) ? 3'd6 : mult_reg);
  wire [3:0]  units   = baud_sel_reg ? {1'b0, n_eff} : ((n_eff > 3'd3) ? 4'd6 : {n_eff, 1'b0});
  wire [15:0] bit_cyc = 16'(`MSL_BIT_CYC(1) / units);

  function automatic logic is_known_op(input logic [7:0] op);
    is_known_op = (op == `MSL_OP_READ) || (op == `MSL_OP_WRITE) || (op == `MSL_OP_INDEXED_READ_CMD) ||
                  (op == `MSL_OP_INDEXED_WRITE_CMD) || (op == `MSL_OP_STACK_POINTER_READ_CMD) || (op == `MSL_OP_RUN);
  endfunction : is_known_op

  msl_uart u_uart
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .bit_cyc  (bit_cyc),
    .line_in  (monitor_serial_pin_in),
    .line_out (monitor_serial_pin_out),
    .line_oe  (monitor_serial_pin_oe),
    .tx_go    (tx_go),
    .tx_brk   (tx_brk),
    .tx_data  (tx_data),
    .tx_busy  (tx_busy),
    .rx_valid (rx_valid),
    .rx_break (rx_break),
    .rx_data  (rx_data)
  );

  // Flash reads while locked give a fixed invalid pattern
  wire        locked   = !sec_ok_reg;
  wire [7:0]  rd_value = (mem_is_flash && locked) ? `MSL_INVALID_DATA : mem_rdata;
  wire [15:0] sec_addr = `MSL_SEC_BASE + {12'h000, sec_idx_reg};
  wire        sec_last = (sec_idx_reg == 4'(`MSL_SEC_COUNT - 1));
  wire        in_cmd   = (state_reg != MSL_SECURE) && (state_reg != MSL_SEC_MEMRD) &&
                         (state_reg != MSL_READY_BRK);

  // Echo has priority; command data queues behind it via tx_busy
  always_comb
  begin
    tx_go   = 1'b0;
    tx_brk  = 1'b0;
    tx_data = rx_data;
    if (rx_valid)
      tx_go = 1'b1;
    else if (!tx_busy)
    begin
      case (state_reg)
        MSL_READY_BRK: begin tx_go = 1'b1; tx_brk = 1'b1; end
        MSL_BRK_ECHO:  begin tx_go = 1'b1; tx_brk = 1'b1; end
        MSL_SEND:      begin tx_go = 1'b1; tx_data = data_reg; end
        MSL_SEND_SP:   begin tx_go = 1'b1; tx_data = sp_lo_reg ? stack_pointer[7:0] : stack_pointer[15:8]; end
        default:       tx_go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg         <= MSL_SECURE;
      addr_reg          <= 16'h0000;
      op_reg            <= 8'h00;
      data_reg          <= 8'h00;
      sec_idx_reg       <= 4'h0;
      sec_done_reg      <= 1'b0;
      iw_pending_reg    <= 1'b0;
      sp_lo_reg         <= 1'b0;
      gap_cnt_reg       <= 16'h0000;
      run_user          <= 1'b0;
    end
    else if (sys_reset_pulse)
    begin
      state_reg   <= MSL_SECURE;
      sec_idx_reg <= 4'h0;
      run_user    <= 1'b0;
    end
    else
    begin
      run_user <= 1'b0;
      if (rx_break && in_cmd)
      begin
        state_reg   <= MSL_BRK_GAP;
        gap_cnt_reg <= 16'(bit_cyc * `MSL_BREAK_GAP_BITS);
      end
      else
      case (state_reg)
        MSL_SECURE:
          if (sec_done_reg)
            state_reg <= MSL_READY_BRK;
          else if (rx_valid)
          begin
            data_reg  <= rx_data;
            state_reg <= MSL_SEC_MEMRD;
          end
        MSL_SEC_MEMRD:
          if (mem_ack)
          begin
            sec_idx_reg <= sec_idx_reg + 4'h1;
            state_reg   <= sec_last ? MSL_READY_BRK : MSL_SECURE;
            if (sec_last)
              sec_done_reg <= 1'b1;
          end
        MSL_READY_BRK:
          if (!tx_busy && !rx_valid)
            state_reg <= MSL_IDLE;
        MSL_IDLE:
          if (rx_valid && is_known_op(rx_data))
          begin
            op_reg <= rx_data;
            case (rx_data)
              `MSL_OP_READ, `MSL_OP_WRITE: state_reg <= MSL_ADDR_HI;
              `MSL_OP_INDEXED_WRITE_CMD:              state_reg <= MSL_DATA_IN;
              `MSL_OP_INDEXED_READ_CMD:
              begin
                addr_reg  <= addr_reg + 16'h0001;
                state_reg <= MSL_MEM_RD;
              end
              `MSL_OP_STACK_POINTER_READ_CMD:
              begin
                sp_lo_reg <= 1'b0;
                state_reg <= MSL_SEND_SP;
              end
              default:
              begin
                run_user  <= 1'b1;
                state_reg <= MSL_IDLE;
              end
            endcase
          end
        MSL_ADDR_HI:
          if (rx_valid)
          begin
            addr_reg[15:8] <= rx_data;
            state_reg      <= MSL_ADDR_LO;
          end
        MSL_ADDR_LO:
          if (rx_valid)
          begin
            addr_reg[7:0] <= rx_data;
            state_reg     <= (op_reg == `MSL_OP_READ) ? MSL_MEM_RD : MSL_DATA_IN;
          end
        MSL_DATA_IN:
          if (rx_valid)
          begin
            data_reg  <= rx_data;
            if (op_reg == `MSL_OP_INDEXED_WRITE_CMD)
              addr_reg <= addr_reg + 16'h0001;
            state_reg <= MSL_MEM_WR;
          end
        MSL_MEM_RD:
          if (mem_ack)
          begin
            data_reg  <= rd_value;
            state_reg <= MSL_SEND;
          end
        MSL_MEM_WR:
          if (mem_ack)
            state_reg <= MSL_IDLE;
        MSL_SEND:
          if (!tx_busy && !rx_valid)
            state_reg <= MSL_IDLE;
        MSL_SEND_SP:
          if (!tx_busy && !rx_valid)
          begin
            sp_lo_reg <= 1'b1;
            if (sp_lo_reg)
              state_reg <= MSL_IDLE;
          end
        MSL_BRK_GAP:
          if (tx_busy || !monitor_serial_pin_in) // Gap counts from the host releasing the line
            gap_cnt_reg <= gap_cnt_reg;
          else if (gap_cnt_reg == 16'h0000)
            state_reg <= MSL_BRK_ECHO;
          else
            gap_cnt_reg <= gap_cnt_reg - 16'h0001;
        MSL_BRK_ECHO:
          if (!tx_busy)
            state_reg <= MSL_IDLE;
        default:
          state_reg <= MSL_IDLE;
      endcase
    end
  end

  // Memory port: security compare reads, command reads and writes
  assign mem_req   = (state_reg == MSL_SEC_MEMRD) || (state_reg == MSL_MEM_RD) || (state_reg == MSL_MEM_WR);
  assign mem_we    = (state_reg == MSL_MEM_WR);
  assign mem_addr  = (state_reg == MSL_SEC_MEMRD) ? sec_addr : addr_reg;
  assign mem_wdata = data_reg;

  // Security flag survives every reset but power-on
  logic sec_match_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_ok_reg    <= 1'b0;
      sec_match_reg <= 1'b1;
    end
    else if (por_pulse)
    begin
      sec_ok_reg    <= 1'b0;
      sec_match_reg <= 1'b1;
    end
    else if (state_reg == MSL_SEC_MEMRD && mem_ack && !sec_ok_reg)
    begin
      if (mem_rdata != data_reg)
        sec_match_reg <= 1'b0;
      if (sec_last)
        sec_ok_reg <= sec_match_reg && (mem_rdata == data_reg);
    end
  end

  // Entry is re-armed only after power-on; sec_done then survives other resets
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      strap_pending_reg <= 1'b1;
    else
      strap_pending_reg <= 1'b0;
  end

  // Strap and multiplier captured just after reset release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud_sel_reg <= 1'b1;
      mult_reg     <= 3'd1;
    end
    else if (strap_pending_reg || sys_reset_pulse || por_pulse)
    begin
      baud_sel_reg <= baud_select_pin;
      mult_reg     <= vco_mult_n;
    end
  end

  // Erased vector detector: asserts one internal reset and latches forced entry in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      forced_reg <= 1'b0;
      ireset_reg <= 1'b0;
      erased_reg <= 1'b0;
    end
    else
    begin
      ireset_reg <= 1'b0;
      if (por_pulse)
        forced_reg <= 1'b0;
      if (vector_fetch && (vector_data == `MSL_ERASED) && !forced_reg && !high_voltage_entry_pin)
      begin
        forced_reg <= 1'b1;
        ireset_reg <= 1'b1;
      end
      if (bulk_erase_done)
        erased_reg <= 1'b1;
      else if (vector_fetch && vector_data != `MSL_ERASED)
        erased_reg <= 1'b0;
    end
  end

  assign forced_monitor     = forced_reg;
  assign monitor_mode       = forced_reg || high_voltage_entry_pin;
  assign internal_reset_req = ireset_reg;
  assign watchdog_enable    = !monitor_mode;
  assign flash_unlocked     = sec_ok_reg;
  assign illegal_addr_reset = run_user && locked && monitor_mode;
  assign security_erased    = erased_reg;

  a_echo_follows: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid && !tx_busy |-> ##1 monitor_serial_pin_oe && !monitor_serial_pin_out)
    else $error("received byte not echoed");
  a_watchdog_off: assert property (@(posedge clock) disable iff (!rst_n)
    forced_reg |-> !watchdog_enable)
    else $error("watchdog on in forced monitor");
  a_no_early_brk: assert property (@(posedge clock) disable iff (!rst_n)
    tx_go && tx_brk |-> sec_done_reg || state_reg == MSL_BRK_ECHO)
    else $error("break before security bytes");
  a_locked_read: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == MSL_MEM_RD && mem_ack && mem_is_flash && !sec_ok_reg
    |=> data_reg == `MSL_INVALID_DATA)
    else $error("locked flash read leaked");
  a_iw_step: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == MSL_DATA_IN && rx_valid && op_reg == `MSL_OP_INDEXED_WRITE_CMD && !rx_break
    |=> addr_reg == $past(addr_reg) + 16'h0001)
    else $error("indexed write did not step");
  a_brk_gap: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(state_reg == MSL_BRK_GAP) |-> !monitor_serial_pin_oe || monitor_serial_pin_out)
    else $error("line not high before break echo");
  a_forced_reset: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(forced_reg) |-> internal_reset_req)
    else $error("no internal reset on erased vectors");
  a_sec_addr: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == MSL_SEC_MEMRD |-> mem_addr >= `MSL_SEC_BASE && mem_addr <= 16'hfffd)
    else $error("security compare out of range");
endmodule : msl_monitor

/* dv/msl_host.sv */
`timescale 1ns/1ps
// Host serial port on the monitor pin; both ends can only pull the wire low
module msl_host
#(
  parameter int BIT_CYC = 1388
)
(
  input  wire logic clock,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      line
);
  logic drive;
  initial drive = 1'b1;
  // Pull-up wire: an idle or released party leaves it high
  assign line = (dev_oe ? dev_out : 1'b1) & drive;

  // Start low, eight bits LSB first; returns at the start of the stop bit
  task automatic send_byte(input logic [7:0] b);
    int i;
    @(negedge clock);
    drive = 1'b0;
    repeat (BIT_CYC) @(negedge clock);
    for (i = 0; i < 8; i++)
    begin
      drive = b[i];
      repeat (BIT_CYC) @(negedge clock);
    end
    drive = 1'b1;
  endtask : send_byte

  // Start bit plus nine low bits
  task automatic send_break();
    @(negedge clock);
    drive = 1'b0;
    repeat (10 * BIT_CYC) @(negedge clock);
    drive = 1'b1;
  endtask : send_break

  // n counts cycles spent waiting for the start edge
  task automatic recv_byte(output logic [7:0] b, output logic brk, output int n);
    int   i;
    logic stop;
    n = 0;
    b = 8'h00;
    brk = 1'b0;
    // Let the wire settle after our own last drive before looking for a start
    @(negedge clock);
    while (line !== 1'b0 && n < 20 * BIT_CYC)
    begin
      @(negedge clock);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge clock);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(negedge clock);
      b[i] = line;
    end
    repeat (BIT_CYC) @(negedge clock);
    stop = line;
    brk = (b === 8'h00) && (stop === 1'b0);
    i = 0;
    while (line !== 1'b1 && i < 4 * BIT_CYC)
    begin
      @(negedge clock);
      i++;
    end
    repeat (BIT_CYC / 2 + 2) @(negedge clock);
  endtask : recv_byte
endmodule : msl_host

/* dv/test_monitor_serial_command_link.sv */
`timescale 1ns/1ps
`include "msl_defs.svh"
module test_monitor_serial_command_link;
  import msl_pkg::*;
  localparam int BIT_CYC = `MSL_BIT_CYC(6);

  logic        clock, rst_n, por_pulse, sys_reset_pulse, vector_fetch, hv_pin, baud_sel;
  logic [7:0]  vector_data, mem_wdata, mem_rdata;
  logic [2:0]  vco_n;
  logic        pin_line, pin_out, pin_oe, mem_req, mem_we, mem_ack, bulk_erase_done;
  logic [15:0] mem_addr, sp;
  logic        monitor_mode, forced_monitor, internal_reset_req, illegal_addr_reset;
  logic        watchdog_enable, flash_unlocked, run_user, security_erased;
  logic [7:0]  mem [0:65535];
  int          miscompares, n_compared;
  logic        run_seen, illegal_seen;

  msl_monitor dut (.clock(clock), .rst_n(rst_n), .por_pulse(por_pulse), .sys_reset_pulse(sys_reset_pulse),
    .vector_fetch(vector_fetch), .vector_data(vector_data), .high_voltage_entry_pin(hv_pin),
    .baud_select_pin(baud_sel), .vco_mult_n(vco_n), .monitor_serial_pin_in(pin_line),
    .monitor_serial_pin_out(pin_out), .monitor_serial_pin_oe(pin_oe), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_is_flash(mem_addr[15]), .stack_pointer(sp), .bulk_erase_done(bulk_erase_done),
    .monitor_mode(monitor_mode), .forced_monitor(forced_monitor), .internal_reset_req(internal_reset_req),
    .illegal_addr_reset(illegal_addr_reset), .watchdog_enable(watchdog_enable),
    .flash_unlocked(flash_unlocked), .run_user(run_user), .security_erased(security_erased));

  msl_host #(.BIT_CYC(BIT_CYC)) host (.clock(clock), .dev_out(pin_out), .dev_oe(pin_oe), .line(pin_line));

  always #12.5 clock = ~clock;

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : pat

  // One-cycle acknowledge, so back-to-back requests are never merged
  always @(negedge clock)
  begin
    mem_ack <= mem_req & ~mem_ack;
    if (mem_req & ~mem_ack & mem_we)
      mem[mem_addr] <= mem_wdata;
  end
  assign mem_rdata = mem[mem_addr];

  // One-cycle pulses are remembered for the scenario that looks afterwards
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      run_seen     <= 1'b0;
      illegal_seen <= 1'b0;
    end
    else
    begin
      if (run_user)
        run_seen <= 1'b1;
      if (illegal_addr_reset)
        illegal_seen <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic xfer(input logic [7:0] b);
    logic [7:0] e;
    logic       brk;
    int         n;
    host.send_byte(b);
    host.recv_byte(e, brk, n);
    check("echo", {brk, e}, {1'b0, b});
    check("echo latency", n <= BIT_CYC, 1'b1);
  endtask : xfer

  task automatic t_forced();
    int n;
    @(negedge clock);
    vector_data = `MSL_ERASED;
    vector_fetch = 1'b1;
    @(negedge clock);
    vector_fetch = 1'b0;
    n = 0;
    while (internal_reset_req !== 1'b1 && n < 16)
    begin
      @(negedge clock);
      n++;
    end
    check("internal reset", internal_reset_req, 1'b1);
    repeat (4) @(negedge clock);
    check("forced mode", {monitor_mode, forced_monitor}, 2'b11);
    check("watchdog off", watchdog_enable, 1'b0);
    sys_reset_pulse = 1'b1;
    @(negedge clock);
    sys_reset_pulse = 1'b0;
    repeat (4) @(negedge clock);
    check("forced after reset", forced_monitor, 1'b1);
    check("watchdog after reset", watchdog_enable, 1'b0);
    $display("test forced_entry done");
  endtask : t_forced

  task automatic t_security();
    logic [7:0] e;
    logic       brk;
    int         n;
    int         i;
    for (i = 0; i < `MSL_SEC_COUNT; i++)
    begin
      check("locked while entering", flash_unlocked, 1'b0);
      xfer(pat(`MSL_SEC_BASE + 16'(i)));
    end
    host.recv_byte(e, brk, n);
    check("ready break", brk, 1'b1);
    check("unlocked", flash_unlocked, 1'b1);
    $display("test security done");
  endtask : t_security

  task automatic t_commands();
    logic [7:0] e;
    logic       brk;
    int         n;
    xfer(`MSL_OP_READ);
    xfer(8'h00);
    xfer(8'hff);
    host.recv_byte(e, brk, n);
    check("read data", e, pat(16'h00ff));
    xfer(`MSL_OP_INDEXED_WRITE_CMD);
    xfer(8'ha5);
    repeat (16) @(negedge clock);
    check("indexed write", mem[16'h0100], 8'ha5);
    xfer(`MSL_OP_STACK_POINTER_READ_CMD);
    host.recv_byte(e, brk, n);
    check("sp high", e, sp[15:8]);
    host.recv_byte(e, brk, n);
    check("sp low", e, sp[7:0]);
    xfer(`MSL_OP_INDEXED_READ_CMD);
    host.recv_byte(e, brk, n);
    check("indexed read", e, pat(16'h0101));
    xfer(`MSL_OP_WRITE);
    xfer(8'h01);
    xfer(8'h02);
    xfer(8'h5a);
    check("memory write", mem[16'h0102], 8'h5a);
    check("no run yet", run_seen, 1'b0);
    xfer(`MSL_OP_RUN);
    check("run unlocked", {run_seen, illegal_seen}, 2'b10);
    $display("test commands done");
  endtask : t_commands

  task automatic t_break();
    logic [7:0] e;
    logic       brk;
    int         n;
    host.send_break();
    host.recv_byte(e, brk, n);
    check("break echo", brk, 1'b1);
    check("gap before echo", (n >= 2 * BIT_CYC) && (n <= 2 * BIT_CYC + 8), 1'b1);
    sys_reset_pulse = 1'b1;
    @(negedge clock);
    sys_reset_pulse = 1'b0;
    repeat (4) @(negedge clock);
    check("unlock kept", flash_unlocked, 1'b1);
    check("not erased", security_erased, 1'b0);
    bulk_erase_done = 1'b1;
    @(negedge clock);
    bulk_erase_done = 1'b0;
    check("erase flagged", security_erased, 1'b1);
    $display("test break done");
  endtask : t_break

  initial
  begin
    int i;
    clock = 1'b0;
    rst_n = 1'b0;
    {por_pulse, sys_reset_pulse, vector_fetch, hv_pin, bulk_erase_done} = 5'h00;
    vector_data = 8'h00;
    baud_sel = 1'b1;
    vco_n = 3'h6;
    sp = 16'hbe21;
    miscompares = 0;
    n_compared = 0;
    for (i = 0; i < 65536; i++)
      mem[i] = pat(16'(i));
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    por_pulse = 1'b1; // Every security attempt follows a power-on reset
    @(negedge clock);
    por_pulse = 1'b0;
    t_forced();
    t_security();
    t_commands();
    t_break();
    end_of_test();
  end

  // About 48 frames of ten 1388-cycle bits, with margin
  initial
  begin
    repeat (800000) @(posedge clock);
    miscompares++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : test_monitor_serial_command_link
